// >>> src/adcotp_pkg.sv
// Package for the converter output test-pattern block: map, layouts, codes
package adcotp_pkg;

  // Register offsets on the serial configuration port
  localparam logic [12:0] OFS_PATTERN_CONTROL = 13'h00_C0;
  localparam logic [12:0] OFS_FIRST_WORD_LOW   = 13'h00_C2;
  localparam logic [12:0] OFS_FIRST_WORD_HIGH  = 13'h00_C3;
  localparam logic [12:0] OFS_SECOND_WORD_LOW  = 13'h00_C4;
  localparam logic [12:0] OFS_SECOND_WORD_HIGH = 13'h00_C5;
  localparam logic [12:0] OFS_CLOCK_DIVIDE     = 13'h00_72;
  localparam logic [12:0] OFS_OUTPUT_MODE      = 13'h00_73;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions in the pattern control register
  localparam int STYLE_MSB = 7;
  localparam int STYLE_LSB = 6;
  localparam int CODE_MSB  = 3;
  localparam int CODE_LSB  = 0;

  // Field positions in the output mode register
  localparam int DRIVE_MSB  = 7;
  localparam int DRIVE_LSB  = 5;
  localparam int CODING_MSB = 2;
  localparam int CODING_LSB = 0;

  // Pattern style
  typedef enum logic [1:0] {
    STYLE_STATIC    = 2'b00,
    STYLE_ALTERNATE = 2'b01
  } adcotp_style_t;

  // Pattern select codes
  localparam logic [3:0] CODE_OFF       = 4'h0;
  localparam logic [3:0] CODE_MIDSCALE  = 4'h1;
  localparam logic [3:0] CODE_POS_FULL  = 4'h2;
  localparam logic [3:0] CODE_NEG_FULL  = 4'h3;
  localparam logic [3:0] CODE_CHECKER   = 4'h4;
  localparam logic [3:0] CODE_ONE_ZERO  = 4'h7;
  localparam logic [3:0] CODE_USER      = 4'h8;

  // Fixed pattern words, 16 bits left aligned on the bus
  localparam logic [15:0] WORD_MIDSCALE = 16'h8000;
  localparam logic [15:0] WORD_ONES     = 16'hFFFF;
  localparam logic [15:0] WORD_ZEROS    = 16'h0000;
  localparam logic [15:0] WORD_CHECK_A  = 16'hAAAA;
  localparam logic [15:0] WORD_CHECK_B  = 16'h5555;

  // Override fields: zero hands control to the absent select pins
  localparam logic [2:0] SEL_PIN_CONTROL = 3'b000;
  localparam logic [2:0] DIV_BY_1        = 3'b001;
  localparam logic [2:0] DRIVE_LVDS_3MA  = 3'b010;
  localparam logic [2:0] CODING_TWOS     = 3'b001;

  // Cycles a new pattern selection waits before it reaches the bus
  localparam int SETTLE_CYC = 4;

  // Serial port framing
  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS  = 8;

  // Request from the serial port to the register file
  typedef struct packed {
    logic        write;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } adcotp_req_t;

  // Applied pattern selection
  typedef struct packed {
    logic [1:0] style;
    logic [3:0] code;
  } adcotp_sel_t;

  // Words of one pattern
  typedef struct packed {
    logic        on;
    logic        two_words;
    logic [15:0] word1;
    logic [15:0] word2;
  } adcotp_words_t;

  // Serial port states
  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_INSTR = 2'b01,
    SPI_DATA  = 2'b10,
    SPI_DONE  = 2'b11
  } adcotp_spi_state_t;

endpackage

// >>> src/adcotp_spi_slave.sv
// Serial configuration port: one instruction word and one data byte per frame
`timescale 1ns/10ps
`default_nettype none

module adcotp_spi_slave (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_csb_n,
  input  wire logic                  spi_sdi,
  output logic                       spi_sdo,
  output logic                       spi_sdo_oe,
  output logic [12:0]                rd_addr,
  input  wire logic [7:0]            rd_data,
  output adcotp_pkg::adcotp_req_t    req,
  output logic                       req_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic [1:0] sclk_sync_q;
  logic       sclk_prev_q;
  logic [1:0] csb_sync_q;
  logic [1:0] sdi_sync_q;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sclk_sync_q <= 2'b00;
      sclk_prev_q <= 1'b0;
      csb_sync_q  <= 2'b11;
      sdi_sync_q  <= 2'b00;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[0], spi_sclk};
      sclk_prev_q <= sclk_sync_q[1];
      csb_sync_q  <= {csb_sync_q[0], spi_csb_n};
      sdi_sync_q  <= {sdi_sync_q[0], spi_sdi};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state
  adcotp_pkg::adcotp_spi_state_t state_q, state_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic [15:0] instr_q, instr_d;
  logic [7:0]  rdsh_q, rdsh_d;
  logic        sdo_q, sdo_d;
  adcotp_pkg::adcotp_req_t req_q, req_d;
  logic        valid_q, valid_d;

  // Next state; sclk must run well below core_clk for edges to be seen
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    instr_d = instr_q;
    rdsh_d  = rdsh_q;
    sdo_d   = sdo_q;
    req_d   = req_q;
    valid_d = 1'b0;
    if (csb_sync_q[1])
    begin
      state_d = adcotp_pkg::SPI_IDLE;
      cnt_d   = 5'd0;
    end
    else
    begin
      case (state_q)
        adcotp_pkg::SPI_IDLE:
        begin
          state_d = adcotp_pkg::SPI_INSTR;
          cnt_d   = 5'd0;
        end
        adcotp_pkg::SPI_INSTR:
        begin
          if (sclk_rise)
          begin
            shift_d = {shift_q[14:0], sdi_sync_q[1]};
            cnt_d   = cnt_q + 5'd1;
            if (cnt_q == 5'(adcotp_pkg::INSTR_BITS - 1))
            begin
              instr_d = {shift_q[14:0], sdi_sync_q[1]};
              state_d = adcotp_pkg::SPI_DATA;
              cnt_d   = 5'd0;
            end
          end
        end
        adcotp_pkg::SPI_DATA:
        begin
          // Read data is fetched at the first falling edge, after decode
          if (sclk_fall)
          begin
            if (cnt_q == 5'd0)
            begin
              sdo_d  = rd_data[7];
              rdsh_d = {rd_data[6:0], 1'b0};
            end
            else
            begin
              sdo_d  = rdsh_q[7];
              rdsh_d = {rdsh_q[6:0], 1'b0};
            end
          end
          if (sclk_rise)
          begin
            shift_d = {shift_q[14:0], sdi_sync_q[1]};
            cnt_d   = cnt_q + 5'd1;
            if (cnt_q == 5'(adcotp_pkg::DATA_BITS - 1))
            begin
              req_d.write = ~instr_q[15];
              req_d.addr  = instr_q[12:0];
              req_d.wdata = {shift_q[6:0], sdi_sync_q[1]};
              valid_d     = ~instr_q[15];
              state_d     = adcotp_pkg::SPI_DONE;
            end
          end
        end
        default:
        begin
          state_d = adcotp_pkg::SPI_DONE;
        end
      endcase
    end
  end

  // Frame registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= adcotp_pkg::SPI_IDLE;
      cnt_q   <= 5'd0;
      shift_q <= 16'h0000;
      instr_q <= 16'h0000;
      rdsh_q  <= 8'h00;
      sdo_q   <= 1'b0;
      req_q   <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      instr_q <= instr_d;
      rdsh_q  <= rdsh_d;
      sdo_q   <= sdo_d;
      req_q   <= req_d;
      valid_q <= valid_d;
    end
  end

  assign rd_addr    = instr_q[12:0];
  assign req        = req_q;
  assign req_valid  = valid_q;
  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = instr_q[15] & (state_q == adcotp_pkg::SPI_DATA);  // Drive only in read data phase

endmodule

`default_nettype wire

// >>> src/adcotp_top.sv
// Output test-pattern generator with its configuration registers
// Operation
// - Pattern replaces results: constant or two words
// - Alternate mode toggles word one and two
// - Enable is unsynchronised; pattern appears cycles later
// - Style bits 7:6: zero static, one alternate
// - Low four bits pick pattern; 0101/0110 reserved
// - Code 0000 off; 0001 midscale 0x8000
// - 0010 all ones; 0011 all zeros
// - 0100 checkerboard; 0111 ones then zeros
// - User first word: low 0xC2, high 0xC3
// - User second word: low 0xC4, high 0xC5
// - Defaults: divide by one, 3mA DDR, twos
`timescale 1ns/10ps
`default_nettype none

module adcotp_top #(
  parameter int DATA_W = 12
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              spi_sclk,
  input  wire logic              spi_csb_n,
  input  wire logic              spi_sdi,
  output logic                   spi_sdo,
  output logic                   spi_sdo_oe,
  input  wire logic [DATA_W-1:0] conv_data,
  output logic [DATA_W-1:0]      out_data,
  output logic                   test_active,
  output logic [2:0]             divider_select,
  output logic [2:0]             driver_select,
  output logic [2:0]             coding_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: pattern words are 16 bits wide
  generate
    if (DATA_W < 1 || DATA_W > 16)
    begin : g_width_check
      $error("DATA_W must be between 1 and 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [12:0]             rd_addr;
  logic [7:0]              rd_data;
  adcotp_pkg::adcotp_req_t req;
  logic                    req_valid;

  adcotp_spi_slave adcotp_spi_slave_i (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .spi_sclk   (spi_sclk),
    .spi_csb_n  (spi_csb_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data),
    .req        (req),
    .req_valid  (req_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] pattern_control_q, pattern_control_d;
  logic [7:0] first_word_low_q, first_word_low_d;
  logic [7:0] first_word_high_q, first_word_high_d;
  logic [7:0] second_word_low_q, second_word_low_d;
  logic [7:0] second_word_high_q, second_word_high_d;
  logic [7:0] clock_divide_q, clock_divide_d;
  logic [7:0] output_mode_q, output_mode_d;

  // Write decode
  always_comb
  begin
    pattern_control_d  = pattern_control_q;
    first_word_low_d   = first_word_low_q;
    first_word_high_d  = first_word_high_q;
    second_word_low_d  = second_word_low_q;
    second_word_high_d = second_word_high_q;
    clock_divide_d     = clock_divide_q;
    output_mode_d      = output_mode_q;
    if (req_valid && req.write)
    begin
      if (req.addr == adcotp_pkg::OFS_PATTERN_CONTROL)
        pattern_control_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_FIRST_WORD_LOW)
        first_word_low_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_FIRST_WORD_HIGH)
        first_word_high_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_SECOND_WORD_LOW)
        second_word_low_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_SECOND_WORD_HIGH)
        second_word_high_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_CLOCK_DIVIDE)
        clock_divide_d = req.wdata;
      else if (req.addr == adcotp_pkg::OFS_OUTPUT_MODE)
        output_mode_d = req.wdata;
    end
  end

  // Register storage
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pattern_control_q  <= adcotp_pkg::RST_BYTE;
      first_word_low_q   <= adcotp_pkg::RST_BYTE;
      first_word_high_q  <= adcotp_pkg::RST_BYTE;
      second_word_low_q  <= adcotp_pkg::RST_BYTE;
      second_word_high_q <= adcotp_pkg::RST_BYTE;
      clock_divide_q     <= adcotp_pkg::RST_BYTE;
      output_mode_q      <= adcotp_pkg::RST_BYTE;
    end
    else
    begin
      pattern_control_q  <= pattern_control_d;
      first_word_low_q   <= first_word_low_d;
      first_word_high_q  <= first_word_high_d;
      second_word_low_q  <= second_word_low_d;
      second_word_high_q <= second_word_high_d;
      clock_divide_q     <= clock_divide_d;
      output_mode_q      <= output_mode_d;
    end
  end

  // Readback; unmapped addresses read as zero
  function automatic logic [7:0] read_mux(input logic [12:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == adcotp_pkg::OFS_PATTERN_CONTROL)
      val = pattern_control_q;
    else if (addr == adcotp_pkg::OFS_FIRST_WORD_LOW)
      val = first_word_low_q;
    else if (addr == adcotp_pkg::OFS_FIRST_WORD_HIGH)
      val = first_word_high_q;
    else if (addr == adcotp_pkg::OFS_SECOND_WORD_LOW)
      val = second_word_low_q;
    else if (addr == adcotp_pkg::OFS_SECOND_WORD_HIGH)
      val = second_word_high_q;
    else if (addr == adcotp_pkg::OFS_CLOCK_DIVIDE)
      val = clock_divide_q;
    else if (addr == adcotp_pkg::OFS_OUTPUT_MODE)
      val = output_mode_q;
    return val;
  endfunction

  // Process form so a register write re-evaluates the mux, not only an address change
  always_comb
  begin
    rd_data = read_mux(rd_addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Defaults stand in for the absent select pins unless overridden
  function automatic logic [2:0] pick(input logic [2:0] ovr, input logic [2:0] dflt);
    return (ovr == adcotp_pkg::SEL_PIN_CONTROL) ? dflt : ovr;
  endfunction

  assign divider_select = pick(clock_divide_q[2:0], adcotp_pkg::DIV_BY_1);
  assign driver_select  = pick(output_mode_q[adcotp_pkg::DRIVE_MSB:adcotp_pkg::DRIVE_LSB],
                               adcotp_pkg::DRIVE_LVDS_3MA);
  assign coding_select  = pick(output_mode_q[adcotp_pkg::CODING_MSB:adcotp_pkg::CODING_LSB],
                               adcotp_pkg::CODING_TWOS);

  ////////////////////////////////////////////////////////////////////////////
  // Pattern word table
  function automatic adcotp_pkg::adcotp_words_t pattern_words(input logic [3:0] code);
    adcotp_pkg::adcotp_words_t w;
    w = '0;
    case (code)
      adcotp_pkg::CODE_MIDSCALE:
        w = '{1'b1, 1'b0, adcotp_pkg::WORD_MIDSCALE, adcotp_pkg::WORD_MIDSCALE};
      adcotp_pkg::CODE_POS_FULL:
        w = '{1'b1, 1'b0, adcotp_pkg::WORD_ONES, adcotp_pkg::WORD_ONES};
      adcotp_pkg::CODE_NEG_FULL:
        w = '{1'b1, 1'b0, adcotp_pkg::WORD_ZEROS, adcotp_pkg::WORD_ZEROS};
      adcotp_pkg::CODE_CHECKER:
        w = '{1'b1, 1'b1, adcotp_pkg::WORD_CHECK_A, adcotp_pkg::WORD_CHECK_B};
      adcotp_pkg::CODE_ONE_ZERO:
        w = '{1'b1, 1'b1, adcotp_pkg::WORD_ONES, adcotp_pkg::WORD_ZEROS};
      adcotp_pkg::CODE_USER:
        w = '{1'b1, 1'b1, {first_word_high_q, first_word_low_q},
              {second_word_high_q, second_word_low_q}};
      default:
        w = '0;  // off and reserved codes pass results through
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Selection settling, phase and output bus
  adcotp_pkg::adcotp_sel_t sel_req;
  adcotp_pkg::adcotp_sel_t sel_q, sel_d;
  logic [3:0]              settle_q, settle_d;
  logic                    phase_q, phase_d;
  logic [DATA_W-1:0]       out_q, out_d;
  logic                    active_q, active_d;
  adcotp_pkg::adcotp_words_t words;
  logic [15:0]             word_now;

  assign sel_req = '{pattern_control_q[adcotp_pkg::STYLE_MSB:adcotp_pkg::STYLE_LSB],
                     pattern_control_q[adcotp_pkg::CODE_MSB:adcotp_pkg::CODE_LSB]};

  // New selection applies only after a fixed wait, on and off alike
  always_comb
  begin
    words    = pattern_words(sel_q.code);  // Here so user word writes are seen at once
    sel_d    = sel_q;
    settle_d = 4'd0;
    if (sel_req != sel_q)
    begin
      settle_d = settle_q + 4'd1;
      if (settle_q == 4'(adcotp_pkg::SETTLE_CYC - 1))
      begin
        sel_d    = sel_req;
        settle_d = 4'd0;
      end
    end
    // Phase restarts at word one whenever alternation is not running
    phase_d = 1'b0;
    if (words.on && words.two_words && sel_q.style == adcotp_pkg::STYLE_ALTERNATE)
      phase_d = ~phase_q;
    word_now = phase_q ? words.word2 : words.word1;
    active_d = words.on;
    out_d    = words.on ? word_now[15 -: DATA_W] : conv_data;
  end

  // Pattern registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sel_q    <= '0;
      settle_q <= 4'd0;
      phase_q  <= 1'b0;
      out_q    <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      sel_q    <= sel_d;
      settle_q <= settle_d;
      phase_q  <= phase_d;
      out_q    <= out_d;
      active_q <= active_d;
    end
  end

  assign out_data    = out_q;
  assign test_active = active_q;

endmodule

`default_nettype wire

// >>> test/adcotp_chk.sv
// Port checker for the converter output test-pattern block
`timescale 1ns/10ps
`default_nettype none

module adcotp_chk #(
  parameter int DATA_W = 12
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              spi_sclk,
  input wire logic              spi_csb_n,
  input wire logic              spi_sdi,
  input wire logic              spi_sdo,
  input wire logic              spi_sdo_oe,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [DATA_W-1:0] out_data,
  input wire logic              test_active,
  input wire logic [2:0]        divider_select,
  input wire logic [2:0]        driver_select,
  input wire logic [2:0]        coding_select
);
  logic [3:0] hi_cnt_q;
  logic [3:0] hi_cnt_d;

  // Cycles since chip select went high; saturates so long idle spans stay cheap
  always_comb
  begin
    hi_cnt_d = hi_cnt_q;
    if (!spi_csb_n)
      hi_cnt_d = 4'h0;
    else if (hi_cnt_q != 4'hF)
      hi_cnt_d = hi_cnt_q + 4'h1;
  end

  // Counter register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      hi_cnt_q <= 4'h0;
    else
      hi_cnt_q <= hi_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset, pass-through and select outputs
  reset_clear_a : assert property (@(posedge core_clk) sys_rst |=>
    out_data == '0 && !test_active && !spi_sdo_oe) else $error("bus not cleared by reset");
  pass_through_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    !test_active && !$past(sys_rst) |-> out_data == $past(conv_data)) else $error("results not passed");
  select_default_a : assert property (@(posedge core_clk) sys_rst |=> divider_select == 3'b001 &&
    driver_select == 3'b010 && coding_select == 3'b001) else $error("select defaults wrong");
  select_nonzero_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    divider_select != 3'b000 && driver_select != 3'b000 && coding_select != 3'b000) else $error("select zero");
  // Pattern timing and read driver; period only judged once the port has been idle long enough
  pattern_period_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    hi_cnt_q == 4'hF && test_active && $past(test_active) && $past(test_active, 2)
    |-> out_data == $past(out_data, 2)) else $error("pattern period not two");
  enable_window_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(test_active) |-> spi_csb_n && hi_cnt_q <= 4'hC) else $error("pattern switched out of window");
  read_in_frame_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(spi_sdo_oe) |-> !spi_csb_n) else $error("read driver outside frame");
  driver_quiet_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    hi_cnt_q == 4'hF |-> !spi_sdo_oe) else $error("read driver left on");
endmodule

bind adcotp_top adcotp_chk #(.DATA_W(DATA_W)) adcotp_chk_i (.core_clk, .sys_rst, .spi_sclk, .spi_csb_n,
  .spi_sdi, .spi_sdo, .spi_sdo_oe, .conv_data, .out_data, .test_active, .divider_select, .driver_select,
  .coding_select);

`default_nettype wire

// >>> test/adcotp_cap_model.sv
// Capture logic model on the far side of the output bus
`timescale 1ns/10ps
`default_nettype none

module adcotp_cap_model #(
  parameter int DATA_W = 12
) (
  input wire logic              core_clk,
  input wire logic [DATA_W-1:0] out_data,
  output logic [DATA_W-1:0]     last_word_q,
  output logic [DATA_W-1:0]     prev_word_q
);
  logic [DATA_W-1:0] last_word_d;
  logic [DATA_W-1:0] prev_word_d;

  // Keeps two samples; assumes nothing about when a pattern starts
  always_comb
  begin
    last_word_d = out_data;
    prev_word_d = last_word_q;
  end

  // Sample every cycle
  always_ff @(posedge core_clk)
  begin
    last_word_q <= last_word_d;
    prev_word_q <= prev_word_d;
  end
endmodule

`default_nettype wire

// >>> test/adcotp_bench.sv
// Self-checking bench for the converter output test-pattern block
`timescale 1ns/10ps
`default_nettype none

module adcotp_bench;
  localparam int DW = 12;
  logic          core_clk;
  logic          sys_rst;
  logic          spi_sclk;
  logic          spi_csb_n;
  logic          spi_sdi;
  logic          spi_sdo;
  logic          spi_sdo_oe;
  logic [DW-1:0] conv_data;
  logic [DW-1:0] out_data;
  logic          test_active;
  logic [2:0]    divider_select;
  logic [2:0]    driver_select;
  logic [2:0]    coding_select;
  logic [DW-1:0] last_word;
  logic [DW-1:0] prev_word;
  int            fail_count;
  int            samples_checked;

  adcotp_top #(.DATA_W(DW)) adcotp_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .conv_data(conv_data), .out_data(out_data), .test_active(test_active),
    .divider_select(divider_select), .driver_select(driver_select), .coding_select(coding_select));
  adcotp_cap_model #(.DATA_W(DW)) adcotp_cap_model_i (.core_clk(core_clk), .out_data(out_data),
    .last_word_q(last_word), .prev_word_q(prev_word));

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // Conversion results change every cycle so a stale bus is visible
  always
  begin
    @(posedge core_clk);
    #1;
    conv_data = conv_data + 12'h3B5;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("Mismatches %0d, compares %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  // One frame; half periods of six cycles keep the serial clock slow enough to be synchronised
  task automatic spi_xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rv);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wd};
    rv = 8'h00;
    spi_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_sclk = 1'b0;
      spi_sdi = frame[i];
      tick(6);
      if (i < 8)
        rv[i] = spi_sdo;
      spi_sclk = 1'b1;
      tick(6);
    end
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    tick(4);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    spi_xfer(1'b0, a, d, unused);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] got;
    spi_xfer(1'b1, a, 8'h00, got);
    cmp_byte(got, exp);
  endtask

  function automatic logic [DW-1:0] top(input logic [15:0] w);
    return w[15 -: DW];
  endfunction

  // Select a pattern, wait a bounded time for it, check two samples if it is on, then switch it off
  task automatic pat_chk(input logic [7:0] ctl, input logic on, input logic [DW-1:0] w1, input logic [DW-1:0] w2);
    int n;
    wr(adcotp_pkg::OFS_PATTERN_CONTROL, ctl);
    n = 0;
    while (test_active !== on && n < 40)
    begin
      tick(1);
      n++;
    end
    tick(20);
    cmp_byte({7'h00, test_active}, {7'h00, on});
    if (on && last_word === w1)
      cmp_word(prev_word, w2);
    else if (on)
    begin
      cmp_word(last_word, w2);
      cmp_word(prev_word, w1);
    end
    wr(adcotp_pkg::OFS_PATTERN_CONTROL, 8'h00);
    tick(20);
    cmp_byte({7'h00, test_active}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the run needs about 0.3 ms
  initial
  begin
    #1_000_000;
    fail_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    spi_sdi = 1'b0;
    conv_data = 12'h000;
    fail_count = 0;
    samples_checked = 0;
    tick(3);
    sys_rst = 1'b0;
    tick(3);
    cmp_byte({2'b00, divider_select, driver_select}, 8'h0A);
    cmp_byte({5'h00, coding_select}, 8'h01);
    for (int a = 8'hC0; a <= 8'hC5; a++)
      rd_chk(13'(a), 8'h00);
    wr(adcotp_pkg::OFS_CLOCK_DIVIDE, 8'h02);
    cmp_byte({5'h00, divider_select}, 8'h02);
    wr(adcotp_pkg::OFS_OUTPUT_MODE, 8'h82);
    cmp_byte({2'b00, driver_select, coding_select}, 8'h22);
    rd_chk(adcotp_pkg::OFS_OUTPUT_MODE, 8'h82);
    wr(adcotp_pkg::OFS_FIRST_WORD_LOW, 8'h34);
    wr(adcotp_pkg::OFS_FIRST_WORD_HIGH, 8'h12);
    wr(adcotp_pkg::OFS_SECOND_WORD_LOW, 8'hCD);
    wr(adcotp_pkg::OFS_SECOND_WORD_HIGH, 8'hAB);
    rd_chk(adcotp_pkg::OFS_FIRST_WORD_HIGH, 8'h12);
    rd_chk(adcotp_pkg::OFS_SECOND_WORD_LOW, 8'hCD);
    pat_chk(8'h01, 1'b1, top(16'h8000), top(16'h8000));
    pat_chk(8'h02, 1'b1, top(16'hFFFF), top(16'hFFFF));
    pat_chk(8'h03, 1'b1, top(16'h0000), top(16'h0000));
    pat_chk(8'h44, 1'b1, top(16'hAAAA), top(16'h5555));
    pat_chk(8'h84, 1'b1, top(16'hAAAA), top(16'hAAAA));
    pat_chk(8'h47, 1'b1, top(16'hFFFF), top(16'h0000));
    pat_chk(8'h48, 1'b1, top(16'h1234), top(16'hABCD));
    pat_chk(8'h08, 1'b1, top(16'h1234), top(16'h1234));
    pat_chk(8'h41, 1'b1, top(16'h8000), top(16'h8000));
    pat_chk(8'h05, 1'b0, '0, '0);
    pat_chk(8'h06, 1'b0, '0, '0);
    pat_chk(8'h00, 1'b0, '0, '0);
    wr(adcotp_pkg::OFS_PATTERN_CONTROL, 8'h44);
    tick(30);
    sys_rst = 1'b1;
    tick(3);
    sys_rst = 1'b0;
    tick(3);
    cmp_byte({7'h00, test_active}, 8'h00);
    cmp_byte({2'b00, divider_select, driver_select}, 8'h0A);
    rd_chk(adcotp_pkg::OFS_PATTERN_CONTROL, 8'h00);
    rd_chk(adcotp_pkg::OFS_FIRST_WORD_LOW, 8'h00);
    finish_test();
  end
endmodule

`default_nettype wire
